// ### rtl/ctm_pkg.sv
// Purpose: shared constants and types for the 32-bit counter/timer
// Assumes: registers are 32-bit words at byte offsets on a simple select/write port
// Notes:   bit layouts of the control registers are fixed here for the whole block

package ctm_pkg;

    localparam int unsigned ADDR_W    = 7;
    localparam int unsigned DATA_W    = 32;
    localparam int unsigned NUM_MATCH = 4;
    localparam int unsigned NUM_FLAGS = 5;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_FLAGS     = 7'h00;
    localparam logic [ADDR_W-1:0] OFF_RUN       = 7'h04;
    localparam logic [ADDR_W-1:0] OFF_COUNT     = 7'h08;
    localparam logic [ADDR_W-1:0] OFF_DIVLIM    = 7'h0C;
    localparam logic [ADDR_W-1:0] OFF_DIVCNT    = 7'h10;
    localparam logic [ADDR_W-1:0] OFF_MATCH_CTL = 7'h14;
    localparam logic [ADDR_W-1:0] OFF_MATCH0    = 7'h18;
    localparam logic [ADDR_W-1:0] OFF_MATCH_STEP = 7'h04;
    localparam logic [ADDR_W-1:0] OFF_CAP_CTL   = 7'h28;
    localparam logic [ADDR_W-1:0] OFF_CAPTURE   = 7'h2C;
    localparam logic [ADDR_W-1:0] OFF_EXT_MATCH = 7'h3C;
    localparam logic [ADDR_W-1:0] OFF_SRC_CTL   = 7'h70;
    localparam logic [ADDR_W-1:0] OFF_PULSE     = 7'h74;

    // field positions
    localparam int unsigned RUN_ENABLE_BIT   = 0;
    localparam int unsigned RUN_RESET_BIT    = 1;
    localparam int unsigned FLAG_CAPTURE_BIT = 4;
    localparam int unsigned MC_INT_BIT       = 0;
    localparam int unsigned MC_RESET_BIT     = 1;
    localparam int unsigned MC_STOP_BIT      = 2;
    localparam int unsigned MC_STRIDE        = 3;
    localparam int unsigned CC_RISE_BIT      = 0;
    localparam int unsigned CC_FALL_BIT      = 1;
    localparam int unsigned CC_INT_BIT       = 2;
    localparam int unsigned EM_CTRL_LSB      = 4;
    localparam int unsigned EM_CTRL_W        = 2;

    // reset values
    localparam logic [DATA_W-1:0]    RST_WORD  = 32'h0000_0000;
    localparam logic [1:0]           RST_RUN   = 2'h0;
    localparam logic [NUM_FLAGS-1:0] RST_FLAGS = 5'h00;
    localparam logic [NUM_MATCH-1:0] RST_EXT   = 4'h0;

    typedef enum logic [1:0] {
        EM_NONE   = 2'b00,
        EM_LOW    = 2'b01,
        EM_HIGH   = 2'b10,
        EM_TOGGLE = 2'b11
    } ctm_ext_action_type;

    typedef enum logic [1:0] {
        SRC_TIMER = 2'b00,
        SRC_RISE  = 2'b01,
        SRC_FALL  = 2'b10,
        SRC_BOTH  = 2'b11
    } ctm_src_mode_type;

endpackage

// ### rtl/ctm_match_if.sv
// Purpose: carrier between the timer core and its match output unit
// Assumes: one clock domain, core_clk
// Notes:   count and countStep are registered in the core

interface ctm_match_if;
    import ctm_pkg::*;

    logic [DATA_W-1:0]                count;
    logic [NUM_MATCH-1:0][DATA_W-1:0] matchValue;
    logic                             countStep;
    logic [NUM_MATCH-1:0]             pulseEn;
    logic [2*NUM_MATCH-1:0]           extCtl;
    logic                             extWrite;
    logic [NUM_MATCH-1:0]             extWdata;
    logic [NUM_MATCH-1:0]             matchEvent;
    logic [NUM_MATCH-1:0]             extState;

    modport timer (
        output count, matchValue, countStep, pulseEn, extCtl, extWrite, extWdata,
        input  matchEvent, extState
    );

    modport unit (
        input  count, matchValue, countStep, pulseEn, extCtl, extWrite, extWdata,
        output matchEvent, extState
    );
endinterface

// ### rtl/ctm_match_unit.sv
// Purpose: match detection and external match / single-edge pulse outputs
// Assumes: countStep is high the cycle after the count took a new value
// Notes:   a match fires once per new count value, not every cycle it holds

module ctm_match_unit (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic clkEn,
    ctm_match_if.unit mif
);
    import ctm_pkg::*;

    wire logic countZero;
    logic [NUM_MATCH-1:0] extState_q;
    logic [NUM_MATCH-1:0] extState_d;

    assign countZero     = mif.countStep && (mif.count == RST_WORD);
    assign mif.extState  = extState_q;

    genvar i;
    generate
        for (i = 0; i < NUM_MATCH; i++) begin : g_ch
            wire logic               hit;
            ctm_ext_action_type      action;

            assign hit               = mif.countStep && (mif.count == mif.matchValue[i]);
            assign mif.matchEvent[i] = hit;
            assign action = ctm_ext_action_type'(mif.extCtl[EM_CTRL_W*i +: EM_CTRL_W]);

            // pulse mode: high on match, low at cycle start; match wins so a zero
            // match value gives a steady high output
            always_comb begin
                extState_d[i] = extState_q[i];
                if (mif.extWrite) begin
                    extState_d[i] = mif.extWdata[i];
                end else if (mif.pulseEn[i]) begin
                    if (hit) begin
                        extState_d[i] = 1'b1;
                    end else if (countZero) begin
                        extState_d[i] = 1'b0;
                    end
                end else if (hit) begin
                    unique case (action)
                        EM_NONE:   extState_d[i] = extState_q[i];
                        EM_LOW:    extState_d[i] = 1'b0;
                        EM_HIGH:   extState_d[i] = 1'b1;
                        EM_TOGGLE: extState_d[i] = ~extState_q[i];
                    endcase
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            extState_q <= RST_EXT;
        end else if (clkEn) begin
            extState_q <= extState_d;
        end
    end
endmodule // ctm_match_unit

// ### rtl/ctm_timer.sv
// Purpose: 32-bit counter/timer with prescaler, capture, four matches and pulse mode
// Assumes: register port is a single-cycle select/write strobe; read data one cycle later
// Notes:   capture_input is asynchronous and is synchronised before use
//
// Summary of operation
// - count advances once per divider_limit+1 ticks
// - divider hits limit: count increments, divider clears
// - divider limit and count are software readable/writable
// - flags show five pending sources; write clears
// - run control disables counting or holds reset
// - capture edge loads count, optional flag
// - counter mode counts capture input edges
// - four matches: continue, stop or reset count
// - match drives output low, high, toggle, none
// - pulse mode: any of four outputs, one sets period
// - stop on match halts count and divider
// - capture control picks edges and flag enable

module ctm_timer (
    input  wire logic                         core_clk,
    input  wire logic                         rstn,
    input  wire logic                         clkEn,
    input  wire logic                         busSel,
    input  wire logic                         busWrite,
    input  wire logic [ctm_pkg::ADDR_W-1:0]   busAddr,
    input  wire logic [ctm_pkg::DATA_W-1:0]   busWdata,
    output      logic [ctm_pkg::DATA_W-1:0]   busRdata,
    input  wire logic                         captureInput,
    output      logic [ctm_pkg::NUM_MATCH-1:0] matchOutputs
);
    import ctm_pkg::*;

    function automatic logic edge_pick(input logic rise, input logic fall,
                                       input logic useRise, input logic useFall);
        edge_pick = (rise & useRise) | (fall & useFall);
    endfunction

    ctm_match_if mif ();

    // state
    logic [NUM_FLAGS-1:0]             flags_q;
    logic [NUM_FLAGS-1:0]             flags_d;
    logic [1:0]                       runCtl_q;
    logic [1:0]                       runCtl_d;
    logic [DATA_W-1:0]                count_q;
    logic [DATA_W-1:0]                count_d;
    logic [DATA_W-1:0]                divLimit_q;
    logic [DATA_W-1:0]                divCount_q;
    logic [DATA_W-1:0]                divCount_d;
    logic [MC_STRIDE*NUM_MATCH-1:0]   matchCtl_q;
    logic [NUM_MATCH-1:0][DATA_W-1:0] matchVal_q;
    logic [2:0]                       capCtl_q;
    logic [DATA_W-1:0]                capture_q;
    logic [DATA_W-1:0]                capture_d;
    logic [2*NUM_MATCH-1:0]           extCtl_q;
    logic [1:0]                       srcCtl_q;
    logic [NUM_MATCH-1:0]             pulseEn_q;
    logic                             step_q;
    logic                             step_d;
    logic [DATA_W-1:0]                rdata_q;
    logic [DATA_W-1:0]                rdata_d;
    logic                             capSync1_q;
    logic                             capSync2_q;
    logic                             capPrev_q;

    // write decode
    wire logic wrEn;
    wire logic wrFlags;
    wire logic wrRun;
    wire logic wrCount;
    wire logic wrDivLim;
    wire logic wrDivCnt;
    wire logic wrMatchCtl;
    wire logic wrCapCtl;
    wire logic wrExt;
    wire logic wrSrc;
    wire logic wrPulse;
    wire logic rdEn;

    assign wrEn       = busSel && busWrite;
    assign rdEn       = busSel && !busWrite;
    assign wrFlags    = wrEn && (busAddr == OFF_FLAGS);
    assign wrRun      = wrEn && (busAddr == OFF_RUN);
    assign wrCount    = wrEn && (busAddr == OFF_COUNT);
    assign wrDivLim   = wrEn && (busAddr == OFF_DIVLIM);
    assign wrDivCnt   = wrEn && (busAddr == OFF_DIVCNT);
    assign wrMatchCtl = wrEn && (busAddr == OFF_MATCH_CTL);
    assign wrCapCtl   = wrEn && (busAddr == OFF_CAP_CTL);
    assign wrExt      = wrEn && (busAddr == OFF_EXT_MATCH);
    assign wrSrc      = wrEn && (busAddr == OFF_SRC_CTL);
    assign wrPulse    = wrEn && (busAddr == OFF_PULSE);

    // capture input edges, taken only from the second sync stage onward
    wire logic capRise;
    wire logic capFall;
    wire logic capEvent;
    wire logic tick;
    ctm_src_mode_type srcMode;

    assign capRise  = capSync2_q & ~capPrev_q;
    assign capFall  = ~capSync2_q & capPrev_q;
    assign capEvent = edge_pick(capRise, capFall,
                                capCtl_q[CC_RISE_BIT], capCtl_q[CC_FALL_BIT]);
    assign srcMode  = ctm_src_mode_type'(srcCtl_q);
    // counter mode replaces the clock tick with input edges; prescaler still applies
    assign tick     = (srcMode == SRC_TIMER) ? 1'b1 :
                      edge_pick(capRise, capFall, srcCtl_q[0], srcCtl_q[1]);

    // counting
    wire logic running;
    wire logic divAdvance;
    wire logic divWrap;
    wire logic [NUM_MATCH-1:0] eqNow;
    wire logic [NUM_MATCH-1:0] resetEn;
    wire logic [NUM_MATCH-1:0] stopEn;
    wire logic [NUM_MATCH-1:0] intEn;
    wire logic resetOnWrap;
    wire logic stopReq;

    // a stop event also blocks the tick of its own cycle, so a zero limit cannot overshoot
    assign running    = runCtl_q[RUN_ENABLE_BIT] && !runCtl_q[RUN_RESET_BIT] && !stopReq;
    assign divAdvance = running && tick;
    assign divWrap    = divAdvance && (divCount_q == divLimit_q);

    genvar i;
    generate
        for (i = 0; i < NUM_MATCH; i++) begin : g_mctl
            assign eqNow[i]   = (count_q == matchVal_q[i]);
            assign intEn[i]   = matchCtl_q[MC_STRIDE*i + MC_INT_BIT];
            assign resetEn[i] = matchCtl_q[MC_STRIDE*i + MC_RESET_BIT];
            assign stopEn[i]  = matchCtl_q[MC_STRIDE*i + MC_STOP_BIT];
            assign mif.matchValue[i] = matchVal_q[i];
        end
    endgenerate

    // reset at the end of the matching count keeps a full-length final cycle
    assign resetOnWrap = divWrap && |(eqNow & resetEn);
    assign stopReq     = |(mif.matchEvent & stopEn);

    always_comb begin
        count_d = count_q;
        if (wrCount) begin
            count_d = busWdata;
        end else if (runCtl_q[RUN_RESET_BIT]) begin
            count_d = RST_WORD;
        end else if (resetOnWrap) begin
            count_d = RST_WORD;
        end else if (divWrap) begin
            count_d = count_q + 32'h0000_0001;
        end
    end

    always_comb begin
        divCount_d = divCount_q;
        if (wrDivCnt) begin
            divCount_d = busWdata;
        end else if (runCtl_q[RUN_RESET_BIT] || divWrap) begin
            divCount_d = RST_WORD;
        end else if (divAdvance) begin
            divCount_d = divCount_q + 32'h0000_0001;
        end
    end

    assign step_d = (count_d != count_q) || resetOnWrap || wrCount;

    // a stop match clears the enable even against a same-cycle software write
    assign runCtl_d = (wrRun ? busWdata[1:0] : runCtl_q)
                    & ~({1'b0, stopReq} << RUN_ENABLE_BIT);

    // hardware set wins over a software clear in the same cycle
    assign flags_d = (flags_q & ~(wrFlags ? busWdata[NUM_FLAGS-1:0] : RST_FLAGS))
                   | {capEvent & capCtl_q[CC_INT_BIT], mif.matchEvent & intEn};

    assign capture_d = capEvent ? count_q : capture_q;

    // read mux; unmapped offsets read zero
    always_comb begin
        rdata_d = RST_WORD;
        unique case (busAddr)
            OFF_FLAGS:     rdata_d = DATA_W'(flags_q);
            OFF_RUN:       rdata_d = DATA_W'(runCtl_q);
            OFF_COUNT:     rdata_d = count_q;
            OFF_DIVLIM:    rdata_d = divLimit_q;
            OFF_DIVCNT:    rdata_d = divCount_q;
            OFF_MATCH_CTL: rdata_d = DATA_W'(matchCtl_q);
            OFF_MATCH0:    rdata_d = matchVal_q[0];
            OFF_MATCH0 + OFF_MATCH_STEP:      rdata_d = matchVal_q[1];
            OFF_MATCH0 + ADDR_W'(2) * OFF_MATCH_STEP: rdata_d = matchVal_q[2];
            OFF_MATCH0 + ADDR_W'(3) * OFF_MATCH_STEP: rdata_d = matchVal_q[3];
            OFF_CAP_CTL:   rdata_d = DATA_W'(capCtl_q);
            OFF_CAPTURE:   rdata_d = capture_q;
            OFF_EXT_MATCH: rdata_d = DATA_W'({extCtl_q, mif.extState});
            OFF_SRC_CTL:   rdata_d = DATA_W'(srcCtl_q);
            OFF_PULSE:     rdata_d = DATA_W'(pulseEn_q);
            default:       rdata_d = RST_WORD;
        endcase
    end

    // match unit link
    assign mif.count     = count_q;
    assign mif.countStep = step_q;
    assign mif.pulseEn   = pulseEn_q;
    assign mif.extCtl    = extCtl_q;
    assign mif.extWrite  = wrExt;
    assign mif.extWdata  = busWdata[NUM_MATCH-1:0];

    ctm_match_unit u_match (
        .core_clk (core_clk),
        .rstn     (rstn),
        .clkEn    (clkEn),
        .mif      (mif)
    );

    assign busRdata     = rdata_q;
    assign matchOutputs = mif.extState;

    // synchroniser: stage one feeds only stage two
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            capSync1_q <= 1'b0;
            capSync2_q <= 1'b0;
            capPrev_q  <= 1'b0;
        end else if (clkEn) begin
            capSync1_q <= captureInput;
            capSync2_q <= capSync1_q;
            capPrev_q  <= capSync2_q;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            count_q    <= RST_WORD;
            divCount_q <= RST_WORD;
            step_q     <= 1'b0;
            runCtl_q   <= RST_RUN;
            flags_q    <= RST_FLAGS;
            capture_q  <= RST_WORD;
            rdata_q    <= RST_WORD;
        end else if (clkEn) begin
            count_q    <= count_d;
            divCount_q <= divCount_d;
            step_q     <= step_d;
            runCtl_q   <= runCtl_d;
            flags_q    <= flags_d;
            capture_q  <= capture_d;
            if (rdEn) begin
                rdata_q <= rdata_d;
            end
        end
    end

    // plain configuration registers
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            divLimit_q <= RST_WORD;
            matchCtl_q <= '0;
            capCtl_q   <= '0;
            extCtl_q   <= '0;
            srcCtl_q   <= '0;
            pulseEn_q  <= '0;
        end else if (clkEn) begin
            if (wrDivLim) begin
                divLimit_q <= busWdata;
            end
            if (wrMatchCtl) begin
                matchCtl_q <= busWdata[MC_STRIDE*NUM_MATCH-1:0];
            end
            if (wrCapCtl) begin
                capCtl_q <= busWdata[2:0];
            end
            if (wrExt) begin
                extCtl_q <= busWdata[EM_CTRL_LSB +: 2*NUM_MATCH];
            end
            if (wrSrc) begin
                srcCtl_q <= busWdata[1:0];
            end
            if (wrPulse) begin
                pulseEn_q <= busWdata[NUM_MATCH-1:0];
            end
        end
    end

    generate
        for (i = 0; i < NUM_MATCH; i++) begin : g_mval
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    matchVal_q[i] <= RST_WORD;
                end else if (clkEn && wrEn
                             && busAddr == OFF_MATCH0 + ADDR_W'(i) * OFF_MATCH_STEP) begin
                    matchVal_q[i] <= busWdata;
                end
            end
        end
    endgenerate
endmodule // ctm_timer

// ### sim/ctm_timer_props.sv
// Purpose: port-level properties of the counter/timer register port and match pins
// Assumes: single clock domain core_clk, asynchronous active-low rstn
// Notes:   sees only top ports, so internal count is judged through reads
module ctm_timer_props (
    input wire logic                          core_clk,
    input wire logic                          rstn,
    input wire logic                          clkEn,
    input wire logic                          busSel,
    input wire logic                          busWrite,
    input wire logic [ctm_pkg::ADDR_W-1:0]    busAddr,
    input wire logic [ctm_pkg::DATA_W-1:0]    busWdata,
    input wire logic [ctm_pkg::DATA_W-1:0]    busRdata,
    input wire logic                          captureInput,
    input wire logic [ctm_pkg::NUM_MATCH-1:0] matchOutputs
);
    import ctm_pkg::*;

    logic [NUM_MATCH-1:0] extWrLow;
    logic                 rdStb;
    logic                 wrStb;
    assign extWrLow = busWdata[NUM_MATCH-1:0];
    assign rdStb    = busSel && !busWrite && clkEn;
    assign wrStb    = busSel && busWrite && clkEn;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence s_rd_count;
        rdStb && busAddr == OFF_COUNT;
    endsequence
    sequence s_wr_hold;
        wrStb && busAddr == OFF_RUN && busWdata[RUN_RESET_BIT];
    endsequence
    sequence s_wr_run_off;
        wrStb && busAddr == OFF_RUN && busWdata == RST_WORD;
    endsequence

    property p_reset_out;
        $rose(rstn) |-> busRdata == RST_WORD && matchOutputs == RST_EXT;
    endproperty
    property p_rdata_holds;
        !rdStb |=> $stable(busRdata);
    endproperty
    property p_unmapped_zero;
        rdStb && busAddr >= 7'h40 && busAddr <= 7'h6C |=> busRdata == RST_WORD;
    endproperty
    property p_word_readback;
        wrStb && (busAddr == OFF_DIVLIM || busAddr inside {[OFF_MATCH0 : 7'h24]})
            ##1 rdStb && busAddr == $past(busAddr) |=> busRdata == $past(busWdata, 2);
    endproperty
    property p_hold_zero;
        s_wr_hold ##1 !(wrStb && busAddr == OFF_RUN) ##1 s_rd_count |=> busRdata == RST_WORD;
    endproperty
    property p_run_off_frozen;
        s_wr_run_off ##1 s_rd_count ##1 s_rd_count |=> busRdata == $past(busRdata);
    endproperty
    property p_ext_write;
        wrStb && busAddr == OFF_EXT_MATCH |=> matchOutputs == $past(extWrLow);
    endproperty
    // a frozen clock enable must not let read data or pins drift
    property p_freeze;
        !clkEn |=> $stable(busRdata) && $stable(matchOutputs);
    endproperty

    a_reset_out: assert property (p_reset_out)
        else $error("outputs not cleared by reset");
    a_rdata_holds: assert property (p_rdata_holds)
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (p_unmapped_zero)
        else $error("unmapped read not zero");
    a_word_readback: assert property (p_word_readback)
        else $error("register read back differs from write");
    a_hold_zero: assert property (p_hold_zero)
        else $error("count not zero under hold");
    a_run_off_frozen: assert property (p_run_off_frozen)
        else $error("count moved while disabled");
    a_ext_write: assert property (p_ext_write)
        else $error("match pins differ from written state");
    a_freeze: assert property (p_freeze)
        else $error("state moved with clock enable low");
endmodule // ctm_timer_props

bind ctm_timer ctm_timer_props u_props (
    .core_clk(core_clk), .rstn(rstn), .clkEn(clkEn), .busSel(busSel), .busWrite(busWrite),
    .busAddr(busAddr), .busWdata(busWdata), .busRdata(busRdata),
    .captureInput(captureInput), .matchOutputs(matchOutputs)
);

// ### sim/ctm_pin_model.sv
// Purpose: far-side pins: drives the capture pin, watches match output 0
// Assumes: pin changes just after a rising edge, held long enough for the synchroniser
// Notes:   the pin is driven at all times, so it never floats
module ctm_pin_model (
    input wire logic                          core_clk,
    input wire logic [ctm_pkg::NUM_MATCH-1:0] matchOutputs,
    output     logic                          captureInput
);
    timeunit 1ns;
    timeprecision 1ps;
    import ctm_pkg::*;

    initial captureInput = 1'b0;

    // six cycles covers two sync flops plus edge register
    task automatic setPin(input logic lvl);
        @(posedge core_clk);
        #2;
        captureInput = lvl;
        repeat (6) @(posedge core_clk);
        #2;
    endtask

    task automatic measure(input int n, output int highs);
        highs = 0;
        repeat (n) begin
            @(posedge core_clk);
            #1;
            if (matchOutputs[0] === 1'b1) highs++;
        end
    endtask
endmodule // ctm_pin_model

// ### sim/ctm_timer_tb_top.sv
// Purpose: self-checking bench for the counter/timer
// Assumes: register port strobes are sampled at the rising edge of core_clk
// Notes:   random values from a fixed seed, corner values mixed in
module ctm_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ctm_pkg::*;

    logic                 core_clk = 1'b0;
    logic                 rstn     = 1'b0;
    logic                 clkEn    = 1'b1;
    logic                 busSel   = 1'b0;
    logic                 busWrite = 1'b0;
    logic [ADDR_W-1:0]    busAddr  = '0;
    logic [DATA_W-1:0]    busWdata = '0;
    logic [DATA_W-1:0]    busRdata;
    wire logic            captureInput;
    logic [NUM_MATCH-1:0] matchOutputs;
    logic [DATA_W-1:0]    rv;
    logic [DATA_W-1:0]    c;
    int                   err_count  = 0;
    int                   num_checks = 0;
    int                   p;
    int                   d;
    int                   hi;
    logic                 s;

    always #12.5 core_clk = ~core_clk;

    ctm_timer u_dut (
        .core_clk(core_clk), .rstn(rstn), .clkEn(clkEn), .busSel(busSel), .busWrite(busWrite),
        .busAddr(busAddr), .busWdata(busWdata), .busRdata(busRdata),
        .captureInput(captureInput), .matchOutputs(matchOutputs)
    );
    ctm_pin_model u_pins (
        .core_clk(core_clk), .matchOutputs(matchOutputs), .captureInput(captureInput)
    );

    function automatic logic [ADDR_W-1:0] mAddr(input int n);
        return OFF_MATCH0 + ADDR_W'(n) * OFF_MATCH_STEP;
    endfunction
    function automatic logic expAct(input int a, input logic st);
        case (ctm_ext_action_type'(a))
            EM_NONE: return st;
            EM_LOW:  return 1'b0;
            EM_HIGH: return 1'b1;
            default: return ~st;
        endcase
    endfunction

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, e, g);
        end
    endtask
    // strobe stays up on return so accesses can run back to back
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] dat);
        busSel = 1'b1; busWrite = 1'b1; busAddr = a; busWdata = dat;
        @(posedge core_clk);
        #2;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] dat);
        busSel = 1'b1; busWrite = 1'b0; busAddr = a;
        @(posedge core_clk);
        #2;
        dat = busRdata;
    endtask
    task automatic idle(input int n);
        busSel = 1'b0;
        repeat (n) @(posedge core_clk);
        #2;
    endtask
    task automatic measure(input logic [31:0] start, input int lim, input int m);
        logic [31:0] a;
        logic [31:0] b;
        int          g;
        g = 1 + $urandom % 7;
        wr(OFF_RUN, 0); wr(OFF_COUNT, start); wr(OFF_DIVCNT, 0); wr(OFF_DIVLIM, 32'(lim));
        wr(OFF_RUN, 32'h1);
        rd(OFF_COUNT, a);
        clkEn = 1'b0;
        idle(g);
        clkEn = 1'b1;
        idle(m * (lim + 1) - 1);
        rd(OFF_COUNT, b);
        chk("count step", 32'(m), b - a);
        wr(OFF_RUN, 0); rd(OFF_COUNT, a); rd(OFF_COUNT, b);
        chk("count stopped", a, b);
    endtask

    initial begin
        #(40000 * 25); // about a hundred times the expected run
        err_count++;
        stop_test();
    end

    initial begin
        void'($urandom(26742));
        repeat (6) @(posedge core_clk);
        #2;
        rstn = 1'b1;
        for (int i = 0; i < 30; i += 1) begin
            rd(ADDR_W'(4 * i), rv);
            chk("reset value", RST_WORD, rv);
        end
        wr(7'h40, 32'hFFFF_FFFF); wr(OFF_CAPTURE, 32'h5A5A_5A5A); rd(7'h40, rv);
        chk("unmapped", RST_WORD, rv);
        rd(OFF_CAPTURE, rv);
        chk("capture read only", RST_WORD, rv);
        for (int k = 0; k < 9; k += 1) begin
            logic [ADDR_W-1:0] ra;
            ra = (k % 3 == 0) ? OFF_DIVLIM : (k % 3 == 1) ? OFF_DIVCNT : mAddr(1);
            c = $urandom;
            wr(ra, c); rd(ra, rv);
            chk("readback", c, rv);
        end
        measure(32'hFFFF_FFFE, 0, 5);
        measure($urandom, 1 + $urandom % 6, 3 + $urandom % 4);
        wr(OFF_RUN, 32'h2); rd(OFF_DIVLIM, rv); rd(OFF_COUNT, rv);
        chk("hold count", RST_WORD, rv);
        p = $urandom % 5; d = 3 + $urandom % 8;
        wr(OFF_RUN, 0); wr(OFF_COUNT, 0); wr(OFF_DIVCNT, 0); wr(OFF_DIVLIM, 32'(p));
        wr(mAddr(0), 32'(d)); wr(OFF_MATCH_CTL, 32'h5); wr(OFF_FLAGS, 32'h1F); wr(OFF_RUN, 32'h1);
        idle((d + 3) * (p + 1));
        rd(OFF_COUNT, rv);
        chk("stop count", 32'(d), rv);
        rd(OFF_RUN, rv);
        chk("stop enable", RST_WORD, rv);
        rd(OFF_DIVCNT, c); idle(3); rd(OFF_DIVCNT, rv);
        chk("divider halted", c, rv);
        rd(OFF_FLAGS, rv);
        chk("match flag", 32'h1, 32'(rv[0]));
        wr(OFF_FLAGS, 32'h1); rd(OFF_FLAGS, rv);
        chk("flag cleared", 32'h0, 32'(rv[0]));
        wr(OFF_MATCH_CTL, 0);
        for (int a = 0; a < 4; a += 1) begin
            s = 1'(($urandom));
            c = $urandom;
            wr(mAddr(2), c);
            wr(OFF_EXT_MATCH, (32'(a) << (EM_CTRL_LSB + 2 * EM_CTRL_W)) | (32'(s) << 2));
            wr(OFF_COUNT, c);
            idle(3);
            chk("match pin action", 32'(expAct(a, s)), 32'(matchOutputs[2]));
        end
        p = 6 + $urandom % 6;
        d = 1 + $urandom % (p - 1);
        wr(mAddr(3), 32'(p)); wr(mAddr(0), 32'(d)); wr(OFF_MATCH_CTL, 32'h400);
        wr(OFF_PULSE, 32'h1); wr(OFF_DIVLIM, 0); wr(OFF_COUNT, 0); wr(OFF_DIVCNT, 0);
        wr(OFF_RUN, 32'h1);
        idle(3 * (p + 1));
        u_pins.measure(4 * (p + 1), hi);
        chk("pulse high cycles", 32'(4 * (p + 1 - d)), 32'(hi));
        wr(OFF_RUN, 0); wr(OFF_PULSE, 0); wr(OFF_MATCH_CTL, 0);
        c = $urandom;
        wr(OFF_CAP_CTL, 32'h5); wr(OFF_FLAGS, 32'h1F); wr(OFF_COUNT, c); idle(1);
        u_pins.setPin(1'b1);
        rd(OFF_CAPTURE, rv);
        chk("capture rise", c, rv);
        rd(OFF_FLAGS, rv);
        chk("capture flag", 32'h1, 32'(rv[FLAG_CAPTURE_BIT]));
        wr(OFF_CAP_CTL, 32'h2); wr(OFF_FLAGS, 32'h1F); wr(OFF_COUNT, c + 1); idle(1);
        u_pins.setPin(1'b0);
        wr(OFF_COUNT, c + 2); idle(1);
        u_pins.setPin(1'b1);
        rd(OFF_CAPTURE, rv);
        chk("capture fall only", c + 1, rv);
        rd(OFF_FLAGS, rv);
        chk("capture flag off", 32'h0, 32'(rv[FLAG_CAPTURE_BIT]));
        d = 2 + $urandom % 5;
        p = 1 + $urandom % 3;
        wr(OFF_CAP_CTL, 0); wr(OFF_SRC_CTL, 32'(p)); wr(OFF_COUNT, 0); wr(OFF_DIVCNT, 0);
        wr(OFF_RUN, 32'h1); idle(1);
        repeat (d) begin
            u_pins.setPin(1'b0);
            u_pins.setPin(1'b1);
        end
        rd(OFF_COUNT, rv);
        chk("edge count", 32'(p == 3 ? 2 * d : d), rv);
        idle(2);
        stop_test();
    end
endmodule // ctm_timer_tb_top
